// ==== ast_pkg.sv ====
// constants, field positions and types shared by the serial core files
// assumes a 32-bit apb slave with byte addresses and one word per register
package ast_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_CTRL3 = 8'h08;
  localparam logic [7:0] OFS_STAT1 = 8'h0C;
  localparam logic [7:0] OFS_STAT2 = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam logic [7:0] OFS_BAUD = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int C1_ENABLE = 0;
  localparam int C1_NINE = 1;
  localparam int C1_INV = 2;
  localparam int C2_TE = 0;
  localparam int C2_RE = 1;
  localparam int C2_BRK = 2;
  localparam int C2_TIE = 3;
  localparam int C2_RIE = 4;
  localparam int C3_TX9 = 0;
  localparam int C3_RX9 = 1;
  localparam int S1_TXE = 0;
  localparam int S1_RXF = 1;
  localparam int S1_NF = 2;
  localparam int S1_FE = 3;
  localparam int S1_OR = 4;
  localparam int S2_BRK = 0;
  localparam int S2_RPF = 1;
  localparam int BAUD_BREAK_LEN_EXT = 16;

  // ---------------------------------------------------------------
  // reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [15:0] BAUD_DIV_RESET = 16'h000C;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] RT3 = 4'h2;
  localparam logic [3:0] RT5 = 4'h4;
  localparam logic [3:0] RT7 = 4'h6;
  localparam logic [3:0] RT8 = 4'h7;
  localparam logic [3:0] RT9 = 4'h8;
  localparam logic [3:0] RT10 = 4'h9;
  localparam logic [3:0] RT16 = 4'hF;

  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;

endpackage

// ==== ast_tx_if.sv ====
// control and data bundle between the core and its transmitter
// assumes both ends run on pclk
`timescale 1ns/1ps
interface ast_tx_if;
  logic en;
  logic tick;
  logic te;
  logic brk;
  logic nine;
  logic break_len_ext;
  logic full;
  logic [8:0] data;
  logic taken;
  logic line;
  modport ctl (output en, tick, te, brk, nine, break_len_ext, full, data, input taken, line);
  modport tx (input en, tick, te, brk, nine, break_len_ext, full, data, output taken, line);
endinterface

// ==== ast_baud.sv ====
// shared sample-rate tick generator (16 ticks per bit time)
// assumes div is stable while en is high; tick period is div+1 clocks
`timescale 1ns/1ps
module ast_baud #(
  parameter int DIV_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q;

  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_width
    $error("ast_baud: DIV_W must lie in 2..16");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (!en || cnt_q >= div) begin
      cnt_q <= '0;
      tick <= en;
    end else begin
      cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule

// ==== ast_tx.sv ====
// transmitter: preamble, data, break and idle framing on the sample tick
// assumes tick comes from the shared generator; inversion is applied outside
`timescale 1ns/1ps
module ast_tx
  import ast_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  ast_tx_if.tx t
);
  logic [12:0] sh_q;
  logic [3:0] bits_q;
  logic [3:0] rt_q;
  logic busy_q;
  logic pre_q;
  logic tail_q;
  logic te_q;
  logic bit_end;
  logic can_load;
  logic load;
  logic sel_brk;
  logic sel_tail;
  logic [12:0] frame;
  logic [3:0] len;

  assign bit_end = t.tick && (rt_q == RT16);
  assign can_load = !busy_q || (bit_end && bits_q == 4'h1);
  assign load = t.en && t.te && can_load && (pre_q || t.brk || tail_q || t.full);
  assign sel_brk = !pre_q && t.brk;
  assign sel_tail = !pre_q && !t.brk && tail_q;
  assign t.taken = load && !pre_q && !t.brk && !tail_q;
  assign t.line = busy_q ? sh_q[0] : 1'b1;

  // frame contents, shifted out from bit 0
  always_comb begin
    len = FRAME_BITS + {3'b000, t.nine};
    if (pre_q) begin
      frame = '1;
    end else if (sel_brk) begin
      frame = '0;
      len = FRAME_BITS + {3'b000, t.nine} + {3'b000, t.break_len_ext};
    end else if (sel_tail) begin
      frame = '1;
      len = 4'h1;
    end else if (t.nine) begin
      frame = {3'b111, t.data, 1'b0};
    end else begin
      frame = {4'b1111, t.data[7:0], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      te_q <= 1'b0;
    end else begin
      te_q <= t.te;
    end
  end

  // a rising enable queues one idle character, even mid-frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 1'b0;
    end else if (t.te && !te_q) begin
      pre_q <= 1'b1;
    end else if (load && pre_q) begin
      pre_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tail_q <= 1'b0;
    end else if (!t.en) begin
      tail_q <= 1'b0;
    end else if (load) begin
      tail_q <= sel_brk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_q <= 4'h0;
    end else if (!t.en || load) begin
      rt_q <= 4'h0;
    end else if (t.tick) begin
      rt_q <= rt_q + 4'h1;
    end
  end

  // frame ends with enable low leave the line idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      bits_q <= 4'h0;
      sh_q <= '1;
    end else if (!t.en) begin
      busy_q <= 1'b0;
      bits_q <= 4'h0;
      sh_q <= '1;
    end else if (load) begin
      busy_q <= 1'b1;
      bits_q <= len;
      sh_q <= frame;
    end else if (busy_q && bit_end) begin
      sh_q <= {1'b1, sh_q[12:1]};
      bits_q <= bits_q - 4'h1;
      if (bits_q == 4'h1) begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule

// ==== ast_core.sv ====
// async serial transmitter and receiver with an apb register file
// assumes a zero-skew pclk; rxd is asynchronous and is synchronised here
`timescale 1ns/1ps

// Notes on behaviour
// - transmitter and receiver run apart but share one tick generator.
// - length bit picks 8 or 9 bits; ninth transmit bit feeds bit 8.
// - ninth receive bit holds bit 8, or a copy of bit 7 in 8-bit mode.
// - a transmission starts with ones, then data framed by 0 start, 1 stop.
// - transmit-empty sets on hand-off to shifter; interrupt when enabled.
// - line idles high; module disable releases the pins.
// - send-break repeats zero characters, ends with the last break then a one.
// - break seen after 10/11 zeros, or 11/12 with extended break length.
// - break sets framing, full and break flags, clears data and ninth bit.
// - idle character is all ones, length by character length.
// - disabling transmitter idles after current frame; re-enable queues an idle.
// - inversion flips every transmitted level.
// - complete character goes to data buffer unless overrun, sets full, interrupt when enabled.
// - receiver samples at sixteen times the bit rate.
// - sample count realigns after start and after a 1 to 0 data change.
// - start search wants a 0 after three 1s, then counts sixteen.
// - start verified by samples 3, 5, 7; one stray 1 flags noise.
// - failed start verification resets the count and restarts the search.
// - data bit is majority of samples 8-10; disagreement flags noise.
// - start bit samples 8-10 only flag noise, never reject.
// - stop bit from samples 8-10; a majority of 0s gives framing error with full.
module ast_core
  import ast_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  output logic tx_irq,
  output logic rx_irq
);

  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_width
    $error("ast_core: DIV_W must lie in 2..16");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic mixed3(input logic [2:0] v);
    mixed3 = (v != 3'b000) && (v != 3'b111);
  endfunction

  function automatic logic [1:0] ones3(input logic [2:0] v);
    ones3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  logic [2:0] ctrl1_q;
  logic [4:0] ctrl2_q;
  logic tx9_q;
  logic [DIV_W-1:0] div_q;
  logic break_len_ext_q;
  logic en;
  logic nine;
  logic rx_on;

  assign en = ctrl1_q[C1_ENABLE];
  assign nine = ctrl1_q[C1_NINE];
  assign rx_on = en && ctrl2_q[C2_RE];

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic wr_data;
  logic rd_data;
  logic rd_stat1;
  logic [31:0] rmux;

  // one wait state: pready rises in the second access cycle
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign wr_data = wr && paddr == OFS_DATA;
  assign rd_data = rd && paddr == OFS_DATA;
  assign rd_stat1 = rd && paddr == OFS_STAT1;
  assign hit = paddr == OFS_CTRL1 || paddr == OFS_CTRL2 || paddr == OFS_CTRL3 || paddr == OFS_STAT1
               || paddr == OFS_STAT2 || paddr == OFS_DATA || paddr == OFS_BAUD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rmux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= 3'b000;
      ctrl2_q <= 5'b00000;
      tx9_q <= 1'b0;
      div_q <= BAUD_DIV_RESET[DIV_W-1:0];
      break_len_ext_q <= 1'b0;
    end else if (wr) begin
      if (paddr == OFS_CTRL1) begin
        ctrl1_q <= pwdata[2:0];
      end
      if (paddr == OFS_CTRL2) begin
        ctrl2_q <= pwdata[4:0];
      end
      if (paddr == OFS_CTRL3) begin
        tx9_q <= pwdata[C3_TX9];
      end
      if (paddr == OFS_BAUD) begin
        div_q <= pwdata[DIV_W-1:0];
        break_len_ext_q <= pwdata[BAUD_BREAK_LEN_EXT];
      end
    end
  end

  // ---------------------------------------------------------------
  // shared tick and transmitter
  // ---------------------------------------------------------------
  logic rt_tick;
  ast_tx_if txb ();

  ast_baud #(
    .DIV_W(DIV_W)
  ) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .en(en),
    .div(div_q),
    .tick(rt_tick)
  );

  ast_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .t(txb)
  );

  logic [7:0] tx_buf_q;
  logic tx_full_q;
  logic tx_empty_q;
  logic tx_armed_q;

  assign txb.en = en;
  assign txb.tick = rt_tick;
  assign txb.te = ctrl2_q[C2_TE];
  assign txb.brk = ctrl2_q[C2_BRK];
  assign txb.nine = nine;
  assign txb.break_len_ext = break_len_ext_q;
  assign txb.full = tx_full_q;
  assign txb.data = {tx9_q, tx_buf_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (wr_data) begin
      tx_buf_q <= pwdata[7:0];
      tx_full_q <= 1'b1;
    end else if (txb.taken) begin
      tx_full_q <= 1'b0;
    end
  end

  // empty flag clears only by status read followed by data write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_q <= 1'b1;
      tx_armed_q <= 1'b0;
    end else begin
      if (txb.taken) begin
        tx_empty_q <= 1'b1;
      end else if (wr_data && tx_armed_q) begin
        tx_empty_q <= 1'b0;
      end
      if (rd_stat1) begin
        tx_armed_q <= 1'b1;
      end else if (wr_data) begin
        tx_armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
      txd_oe <= 1'b0;
    end else begin
      txd <= en ? (txb.line ^ ctrl1_q[C1_INV]) : 1'b1;
      txd_oe <= en;
    end
  end

  // ---------------------------------------------------------------
  // receiver sampling
  // ---------------------------------------------------------------
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_last_q;
  logic [2:0] hist_q;
  ast_rx_state_t rx_st_q;
  logic [3:0] rt_q;
  logic [3:0] bit_q;
  logic [1:0] smp_q;
  logic s3_q;
  logic s5_q;
  logic noise_q;
  logic ext_q;
  logic prev_q;
  logic [8:0] rx_sh_q;
  logic [2:0] votes;
  logic fall;
  logic data_edge;
  logic stop_eval;
  logic cand;
  logic done;
  logic done_brk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_last_q <= 1'b1;
    end else if (rt_tick) begin
      rx_last_q <= rx_s2_q;
    end
  end

  assign votes = {smp_q, rx_s2_q};
  assign fall = rx_last_q && !rx_s2_q;
  assign data_edge = rx_st_q == RX_DATA && fall && prev_q && (rt_q < RT8 || rt_q > RT10);
  assign stop_eval = rx_on && rt_tick && rx_st_q == RX_STOP && rt_q == RT10;
  assign cand = rx_sh_q == 9'h000 && !maj3(votes);
  assign done = stop_eval && !(cand && break_len_ext_q && !ext_q);
  assign done_brk = done && cand;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_HUNT;
      hist_q <= 3'b000;
      rt_q <= 4'h0;
      bit_q <= 4'h0;
      smp_q <= 2'b00;
      s3_q <= 1'b0;
      s5_q <= 1'b0;
      noise_q <= 1'b0;
      ext_q <= 1'b0;
      prev_q <= 1'b0;
      rx_sh_q <= 9'h000;
    end else if (!rx_on) begin
      rx_st_q <= RX_HUNT;
      hist_q <= 3'b000;
      rt_q <= 4'h0;
    end else if (rt_tick) begin
      rt_q <= rt_q + 4'h1;
      if (rt_q == RT8 || rt_q == RT9) begin
        smp_q <= {smp_q[0], rx_s2_q};
      end
      unique case (rx_st_q)
        RX_HUNT: begin
          hist_q <= {hist_q[1:0], rx_s2_q};
          rt_q <= 4'h0;
          if (hist_q == 3'b111 && !rx_s2_q) begin
            rx_st_q <= RX_START;
            rt_q <= 4'h1;
            noise_q <= 1'b0;
            ext_q <= 1'b0;
            prev_q <= 1'b0;
            bit_q <= 4'h0;
            rx_sh_q <= 9'h000;
          end
        end
        RX_START: begin
          if (rt_q == RT3) begin
            s3_q <= rx_s2_q;
          end
          if (rt_q == RT5) begin
            s5_q <= rx_s2_q;
          end
          if (rt_q == RT7) begin
            if (ones3({s3_q, s5_q, rx_s2_q}) > 2'd1) begin
              rx_st_q <= RX_HUNT;
              hist_q <= 3'b000;
              rt_q <= 4'h0;
            end else if (ones3({s3_q, s5_q, rx_s2_q}) == 2'd1) begin
              noise_q <= 1'b1;
            end
          end
          if (rt_q == RT10 && votes != 3'b000) begin
            noise_q <= 1'b1;
          end
          if (rt_q == RT16) begin
            rx_st_q <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rt_q == RT10) begin
            rx_sh_q[bit_q] <= maj3(votes);
            prev_q <= maj3(votes);
            if (mixed3(votes)) begin
              noise_q <= 1'b1;
            end
          end
          if (data_edge) begin
            rt_q <= 4'h1;
          end
          if (rt_q == RT16 || (data_edge && rt_q > RT10)) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == DATA_BITS - 4'h1 + {3'b000, nine}) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rt_q == RT10) begin
            if (mixed3(votes)) begin
              noise_q <= 1'b1;
            end
            if (cand && break_len_ext_q && !ext_q) begin
              ext_q <= 1'b1;
            end else begin
              rx_st_q <= RX_HUNT;
              hist_q <= 3'b000;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receive buffer and flags
  // ---------------------------------------------------------------
  logic [7:0] rx_buf_q;
  logic rx9_q;
  logic rx_full_q;
  logic nf_q;
  logic fe_q;
  logic or_q;
  logic bkf_q;
  logic rx_armed_q;
  logic rx_clr;
  logic ovr;

  assign rx_clr = rd_data && rx_armed_q;
  assign ovr = done && rx_full_q && !rx_clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= 8'h00;
      rx9_q <= 1'b0;
    end else if (done_brk) begin
      rx_buf_q <= 8'h00;
      rx9_q <= 1'b0;
    end else if (done && !ovr) begin
      rx_buf_q <= rx_sh_q[7:0];
      rx9_q <= nine ? rx_sh_q[8] : rx_sh_q[7];
    end
  end

  // hardware sets win over the software clear sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      or_q <= 1'b0;
      rx_armed_q <= 1'b0;
    end else begin
      if (done) begin
        rx_full_q <= 1'b1;
      end else if (rx_clr) begin
        rx_full_q <= 1'b0;
      end
      if (done && (noise_q || mixed3(votes))) begin
        nf_q <= 1'b1;
      end else if (rx_clr) begin
        nf_q <= 1'b0;
      end
      if (done && (ext_q || !maj3(votes))) begin
        fe_q <= 1'b1;
      end else if (rx_clr) begin
        fe_q <= 1'b0;
      end
      if (ovr) begin
        or_q <= 1'b1;
      end else if (rx_clr) begin
        or_q <= 1'b0;
      end
      if (rd_stat1) begin
        rx_armed_q <= 1'b1;
      end else if (rd_data) begin
        rx_armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bkf_q <= 1'b0;
    end else if (done_brk) begin
      bkf_q <= 1'b1;
    end else if (wr && paddr == OFS_STAT2 && pwdata[S2_BRK]) begin
      bkf_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      tx_irq <= tx_empty_q && ctrl2_q[C2_TIE];
      rx_irq <= rx_full_q && ctrl2_q[C2_RIE];
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rmux = 32'h00000000;
    unique case (paddr)
      OFS_CTRL1: rmux[2:0] = ctrl1_q;
      OFS_CTRL2: rmux[4:0] = ctrl2_q;
      OFS_CTRL3: rmux[1:0] = {rx9_q, tx9_q};
      OFS_STAT1: rmux[4:0] = {or_q, fe_q, nf_q, rx_full_q, tx_empty_q};
      OFS_STAT2: rmux[1:0] = {rx_st_q != RX_HUNT, bkf_q};
      OFS_DATA: rmux[7:0] = rx_buf_q;
      OFS_BAUD: rmux = {15'h0000, break_len_ext_q, 16'(div_q)};
      default: rmux = 32'h00000000;
    endcase
  end

endmodule

// ==== ast_core_properties.sv ====
// checker on the ast_core ports: apb timing and serial pin relations
// assumes it is bound to ast_core and sees only that module's ports
`timescale 1ns/1ps
module ast_core_properties
  import ast_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  logic acc;
  logic en_wr;
  logic tx_clr;
  logic rx_clr;
  assign acc = psel && penable && pready;
  assign en_wr = acc && pwrite && paddr == OFS_CTRL1 && pwdata[C1_ENABLE];
  assign tx_clr = acc && pwrite && paddr inside {OFS_CTRL1, OFS_CTRL2, OFS_DATA};
  assign rx_clr = acc && (paddr == OFS_DATA || (pwrite && paddr inside {OFS_CTRL1, OFS_CTRL2}));
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_one_wait; !pready ##1 pready; endsequence
  property p_ready_wait; psel && $rose(penable) |-> s_one_wait; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait state");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_zero; pslverr && !pwrite |-> pready && prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  property p_idle_off; !txd_oe |-> txd; endproperty
  a_idle_off: assert property (p_idle_off) else $error("released pin not high");
  property p_bit_hold; txd_oe && $past(txd_oe) && $changed(txd) |=> $stable(txd) [*8]; endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("serial bit too short");
  property p_oe_cause; $rose(txd_oe) |-> $past(en_wr) || $past(en_wr, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin driven without enable");
  property p_tx_irq_off; $fell(tx_irq) |-> $past(tx_clr) || $past(tx_clr, 2) || $past(tx_clr, 3); endproperty
  a_tx_irq_off: assert property (p_tx_irq_off) else $error("transmit request dropped alone");
  property p_rx_irq_off; $fell(rx_irq) |-> $past(rx_clr) || $past(rx_clr, 2) || $past(rx_clr, 3); endproperty
  a_rx_irq_off: assert property (p_rx_irq_off) else $error("receive request dropped alone");
endmodule

bind ast_core ast_core_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txd(txd), .txd_oe(txd_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));

// ==== ast_far_end.sv ====
// far-end serial device: sends frames on rxd, captures frames from txd
// assumes the core divisor is 0, so a bit is 16 clocks
`timescale 1ns/1ps
module ast_far_end (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'h1;
  task automatic send_bits(input logic [15:0] b, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      rxd <= b[i];
      repeat (bt) @(posedge pclk);
    end
    rxd <= 1'h1;
  endtask
  task automatic get_frame(input int n, input logic inv, output logic [15:0] b, output logic ok);
    int w;
    b = 16'h0;
    w = 0;
    while ((txd ^ inv) !== 1'h0 && w < 4000) begin
      @(posedge pclk);
      w++;
    end
    ok = (w < 4000);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd ^ inv;
      repeat (16) @(posedge pclk);
    end
  endtask
endmodule

// ==== testbench.sv ====
// bench for ast_core: registers, transmit, break and receive frames
// assumes ast_far_end on the serial pins and the bound checker
`timescale 1ns/1ps
module testbench
  import ast_pkg::*;
;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] fr;
  logic pready, pslverr, er, ok, rxd, txd, txd_oe, tx_irq, rx_irq;
  int mismatches = 0;
  int tests_run = 0;
  int cnt;
  always #20 pclk = ~pclk;
  ast_core i_ast_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
  ast_far_end i_ast_far_end (.pclk(pclk), .txd(txd), .rxd(rxd));
  task automatic final_report;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic give_up(input logic hit);
    if (hit) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    give_up(n == 20);
  endtask
  task automatic rw(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic t_reset_values;
    rw(OFS_CTRL1, 32'h0);
    rw(OFS_STAT1, 32'h1);
    rw(OFS_STAT2, 32'h0);
    rw(OFS_BAUD, 32'h0000000C);
    rw(8'h1C, 32'h0);
    check(er, 1'h1);
    apb(1'h1, 8'h1C, 32'hFFFFFFFF);
    check(er, 1'h1);
  endtask
  task automatic t_tx(input logic [31:0] c1, input logic t9, input logic [7:0] d, input int n, input logic [15:0] e);
    apb(1'h1, OFS_CTRL1, 32'h0);
    apb(1'h1, OFS_CTRL1, c1);
    @(posedge pclk);
    check(txd_oe, 1'h1);
    apb(1'h1, OFS_CTRL3, {31'h0, t9});
    apb(1'h0, OFS_STAT1, 32'h0);
    apb(1'h1, OFS_DATA, {24'h0, d});
    i_ast_far_end.get_frame(n, c1[C1_INV], fr, ok);
    give_up(!ok);
    check(fr, e);
    check(txd, {31'h0, !c1[C1_INV]});
    check(tx_irq, 1'h1);
  endtask
  task automatic t_break;
    apb(1'h1, OFS_CTRL1, 32'h0);
    apb(1'h1, OFS_CTRL1, 32'h1);
    apb(1'h1, OFS_CTRL2, 32'h1F);
    cnt = 0;
    while (txd !== 1'h0 && cnt < 400) begin
      @(posedge pclk);
      cnt++;
    end
    give_up(cnt == 400);
    cnt = 0;
    fork
      while (txd === 1'h0 && cnt < 999) begin
        @(posedge pclk);
        cnt++;
      end
      begin
        repeat (8) @(posedge pclk);
        apb(1'h1, OFS_CTRL2, 32'h1B);
      end
    join
    check(cnt, 32'hA0);
  endtask
  task automatic t_rx_reject;
    i_ast_far_end.send_bits(16'h0, 1, 4);
    repeat (300) @(posedge pclk);
    check(rx_irq, 1'h0);
    rw(OFS_STAT1, 32'h1);
  endtask
  task automatic t_rx(input logic [15:0] b, input logic [31:0] c3, st, bk, d);
    i_ast_far_end.send_bits(b, 10, 16);
    cnt = 0;
    while (rx_irq !== 1'h1 && cnt < 99) begin
      @(posedge pclk);
      cnt++;
    end
    give_up(cnt == 99);
    rw(OFS_CTRL3, c3);
    rw(OFS_STAT2, bk);
    rw(OFS_STAT1, st);
    rw(OFS_DATA, d);
    apb(1'h1, OFS_STAT2, 32'h1);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset_values();
    apb(1'h1, OFS_BAUD, 32'h0);
    apb(1'h1, OFS_CTRL2, 32'h1B);
    t_tx(32'h1, 1'h0, 8'hA5, 10, 16'h034A);
    t_tx(32'h7, 1'h1, 8'h3C, 11, 16'h0678);
    t_break();
    t_rx_reject();
    t_rx(16'h032C, 32'h3, 32'h3, 32'h0, 32'h96);
    t_rx(16'h00AA, 32'h1, 32'hB, 32'h0, 32'h55);
    t_rx(16'h0000, 32'h1, 32'hB, 32'h1, 32'h0);
    final_report();
  end
endmodule
